// File: rtl/arx_pkg.sv
// arx_pkg: register map, field positions and reset values of the converter result block
// assumes a 32-bit AXI4-Lite master and one clock domain
package arx_pkg;

    localparam int unsigned AXI_AW = 6;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [5:0] OFS_AE_LOW   = 6'h00;
    localparam logic [5:0] OFS_AE_HIGH  = 6'h04;
    localparam logic [5:0] OFS_RESULT   = 6'h08;
    localparam logic [5:0] OFS_XFER_MOD = 6'h0C;
    localparam logic [5:0] OFS_XFER_CNT = 6'h10;
    localparam logic [5:0] OFS_XFER_SA  = 6'h14;
    localparam logic [5:0] OFS_FORMAT   = 6'h18;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h1C;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h20;

    // ************************************************************
    // fields
    // ************************************************************
    localparam logic [7:0]  AE_HIGH_MASK  = 8'hF0;
    localparam int unsigned MODE_TB_BIT   = 3;
    localparam int unsigned MODE_CT_BIT   = 2;
    localparam int unsigned MODE_B1_BIT   = 1;
    localparam int unsigned MODE_FE_BIT   = 0;
    localparam logic [7:0]  MODE_WR_MASK  = 8'h0D;
    localparam logic [15:0] SA_WR_MASK    = 16'hFFFE;
    localparam int unsigned RES_W         = 10;
    localparam int unsigned LJ_PAD        = 6;
    localparam logic [7:0]  RESET_8       = 8'h00;
    localparam logic [15:0] RESET_16      = 16'h0000;
    localparam logic [7:0]  CNT_ONE       = 8'h01;
    localparam logic [7:0]  CNT_ZERO      = 8'h00;

    // interrupt status bits
    localparam int unsigned IRQ_W         = 2;
    localparam int unsigned IRQ_DONE_BIT  = 0;
    localparam int unsigned IRQ_BLOCK_BIT = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ARX_IDLE  = 2'b00,
        ARX_BLK1  = 2'b01,
        ARX_BLK2  = 2'b11
    } arx_xfer_state_t;

    typedef struct packed {
        logic              valid;
        logic [RES_W-1:0]  data;
    } arx_sample_t;

endpackage

// File: rtl/arx_regs.sv
// arx_regs: analog enables, result formatting and transfer-mode control behind AXI4-Lite
// assumes conversion results arrive as one-cycle strobes on clk_in; one clock, async reset
`timescale 1ns/1ps
`default_nettype none
module arx_regs (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire logic [arx_pkg::AXI_AW-1:0]  s_axi_awaddr_in,
    input  wire logic                        s_axi_awvalid_in,
    output logic                             s_axi_awready_out,
    input  wire logic [31:0]                 s_axi_wdata_in,
    input  wire logic [3:0]                  s_axi_wstrb_in,
    input  wire logic                        s_axi_wvalid_in,
    output logic                             s_axi_wready_out,
    output logic [1:0]                       s_axi_bresp_out,
    output logic                             s_axi_bvalid_out,
    input  wire logic                        s_axi_bready_in,
    input  wire logic [arx_pkg::AXI_AW-1:0]  s_axi_araddr_in,
    input  wire logic                        s_axi_arvalid_in,
    output logic                             s_axi_arready_out,
    output logic [31:0]                      s_axi_rdata_out,
    output logic [1:0]                       s_axi_rresp_out,
    output logic                             s_axi_rvalid_out,
    input  wire logic                        s_axi_rready_in,
    input  wire arx_pkg::arx_sample_t        sample_in,
    output logic [15:0]                      analog_pin_enable_out,
    output logic                             xfer_write_out,
    output logic [15:0]                      xfer_addr_out,
    output logic                             xfer_active_out,
    output logic                             irq_out
);

    // ************************************************************
    // write channel capture
    // ************************************************************
    logic                       aw_hold_q;
    logic [arx_pkg::AXI_AW-1:0] aw_addr_q;
    logic                       w_hold_q;
    logic [31:0]                w_data_q;
    logic [3:0]                 w_strb_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       wr_go;

    assign s_axi_awready_out = !aw_hold_q && !bvalid_q;
    assign s_axi_wready_out  = !w_hold_q && !bvalid_q;
    assign wr_go             = aw_hold_q && w_hold_q && !bvalid_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
        end
        else if (wr_go)
        begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            w_hold_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
        end
        else if (wr_go)
        begin
            w_hold_q <= 1'b0;
        end
    end

    // write decode; byte lane 0 carries all 8-bit registers
    logic wr_lo;
    logic wr_hi;
    logic known_wr;
    assign wr_lo = wr_go && w_strb_q[0];
    assign wr_hi = wr_go && w_strb_q[1];

    always_comb
    begin
        unique case (aw_addr_q)
            arx_pkg::OFS_AE_LOW, arx_pkg::OFS_AE_HIGH, arx_pkg::OFS_RESULT,
            arx_pkg::OFS_XFER_MOD, arx_pkg::OFS_XFER_CNT, arx_pkg::OFS_XFER_SA,
            arx_pkg::OFS_FORMAT, arx_pkg::OFS_IRQ_STAT, arx_pkg::OFS_IRQ_MASK:
                known_wr = 1'b1;
            default:
                known_wr = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= arx_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= known_wr ? arx_pkg::RESP_OKAY : arx_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready_in)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // software registers
    // ************************************************************
    logic [7:0]  ae_low_q;
    logic [7:0]  ae_high_q;
    logic [7:0]  mode_q;
    logic [7:0]  count_q;
    logic [15:0] sa_q;
    logic        format_q;
    logic [arx_pkg::IRQ_W-1:0] irq_mask_q;
    logic        sa_wr;

    assign sa_wr = wr_lo && aw_addr_q == arx_pkg::OFS_XFER_SA;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ae_low_q   <= arx_pkg::RESET_8;
            ae_high_q  <= arx_pkg::RESET_8;
            mode_q     <= arx_pkg::RESET_8;
            count_q    <= arx_pkg::RESET_8;
            sa_q       <= arx_pkg::RESET_16;
            format_q   <= 1'b0;
            irq_mask_q <= '0;
        end
        else if (wr_lo)
        begin
            unique case (aw_addr_q)
                arx_pkg::OFS_AE_LOW:   ae_low_q  <= w_data_q[7:0];
                arx_pkg::OFS_AE_HIGH:  ae_high_q <= w_data_q[7:0] & arx_pkg::AE_HIGH_MASK;
                arx_pkg::OFS_XFER_MOD: mode_q    <= w_data_q[7:0] & arx_pkg::MODE_WR_MASK;
                arx_pkg::OFS_XFER_CNT: count_q   <= w_data_q[7:0];
                arx_pkg::OFS_XFER_SA:
                begin
                    sa_q[7:0] <= w_data_q[7:0] & arx_pkg::SA_WR_MASK[7:0];
                    if (wr_hi)
                    begin
                        sa_q[15:8] <= w_data_q[15:8];
                    end
                end
                arx_pkg::OFS_FORMAT:   format_q   <= w_data_q[0];
                arx_pkg::OFS_IRQ_MASK: irq_mask_q <= w_data_q[arx_pkg::IRQ_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    // enables drive the pin switches; the logic holds unbuilt channels 11 to 8 at zero
    assign analog_pin_enable_out = {ae_high_q[7:4], 4'h0, ae_low_q};

    // ************************************************************
    // transfer controller
    // ************************************************************
    arx_pkg::arx_xfer_state_t state_q;
    logic [7:0]  left_q;
    logic [15:0] ptr_q;
    logic        filled_b1_q;
    logic        done_seen_q;
    logic [9:0]  result_q;
    logic        blk_done;
    logic        active;
    logic        wr_addr_q;

    assign active   = state_q != arx_pkg::ARX_IDLE;
    assign blk_done = active && sample_in.valid && left_q == arx_pkg::CNT_ONE;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            result_q <= '0;
        end
        else if (sample_in.valid)
        begin
            result_q <= sample_in.data;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q     <= arx_pkg::ARX_IDLE;
            left_q      <= arx_pkg::CNT_ZERO;
            ptr_q       <= arx_pkg::RESET_16;
            filled_b1_q <= 1'b0;
            done_seen_q <= 1'b0;
            wr_addr_q   <= 1'b0;
        end
        else if (sa_wr)
        begin
            // a start address write stops any run and restarts at block one, or goes idle if the count is zero
            state_q     <= (count_q == arx_pkg::CNT_ZERO) ? arx_pkg::ARX_IDLE
                                                          : arx_pkg::ARX_BLK1;
            left_q      <= count_q;
            ptr_q       <= {w_data_q[15:1], 1'b0};
            done_seen_q <= 1'b0;
            wr_addr_q   <= 1'b0;
        end
        else if (active && count_q == arx_pkg::CNT_ZERO)
        begin
            state_q <= arx_pkg::ARX_IDLE;
        end
        else if (active && sample_in.valid)
        begin
            ptr_q     <= ptr_q + 16'h0002;
            wr_addr_q <= 1'b1;
            if (blk_done)
            begin
                done_seen_q <= 1'b1;
                left_q      <= count_q;
                if (state_q == arx_pkg::ARX_BLK1 && mode_q[arx_pkg::MODE_TB_BIT])
                begin
                    state_q     <= arx_pkg::ARX_BLK2;
                    filled_b1_q <= 1'b1;
                end
                else
                begin
                    filled_b1_q <= 1'b0;
                    if (mode_q[arx_pkg::MODE_CT_BIT])
                    begin
                        state_q <= arx_pkg::ARX_BLK1;
                        ptr_q   <= sa_q;
                    end
                    else
                    begin
                        state_q <= arx_pkg::ARX_IDLE;
                    end
                end
            end
            else
            begin
                left_q <= left_q - arx_pkg::CNT_ONE;
            end
        end
        else if (state_q == arx_pkg::ARX_BLK1 && left_q == count_q && wr_addr_q
                 && !mode_q[arx_pkg::MODE_CT_BIT] && done_seen_q)
        begin
            // continuous cleared while waiting to restart: halt at the block boundary
            state_q <= arx_pkg::ARX_IDLE;
        end
    end

    // fetch bit is stored only; it has no effect here
    assign xfer_active_out = active;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            xfer_write_out <= 1'b0;
            xfer_addr_out  <= arx_pkg::RESET_16;
        end
        else
        begin
            xfer_write_out <= active && sample_in.valid && !sa_wr;
            xfer_addr_out  <= ptr_q;
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    logic [arx_pkg::IRQ_W-1:0] irq_stat_q;
    logic [arx_pkg::IRQ_W-1:0] irq_set;
    logic [arx_pkg::IRQ_W-1:0] irq_clr;

    assign irq_set = {blk_done, sample_in.valid};
    assign irq_clr = (wr_lo && aw_addr_q == arx_pkg::OFS_IRQ_STAT)
                   ? w_data_q[arx_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_stat_q <= '0;
        end
        else
        begin
            // set wins over a same-cycle clear
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    assign irq_out = |(irq_stat_q & irq_mask_q);

    // ************************************************************
    // read channel
    // ************************************************************
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [15:0] fmt_result;
    logic [7:0]  mode_rd;

    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;

    always_comb
    begin
        if (format_q)
        begin
            // offset binary to two's complement: flip the msb
            fmt_result = {~result_q[arx_pkg::RES_W-1], result_q[arx_pkg::RES_W-2:0],
                          {arx_pkg::LJ_PAD{1'b0}}};
        end
        else
        begin
            fmt_result = {{arx_pkg::LJ_PAD{1'b0}}, result_q};
        end
        mode_rd = mode_q;
        mode_rd[arx_pkg::MODE_B1_BIT] = filled_b1_q && done_seen_q
                                        && mode_q[arx_pkg::MODE_TB_BIT];
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= arx_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= arx_pkg::RESP_OKAY;
            unique case (s_axi_araddr_in)
                arx_pkg::OFS_AE_LOW:   rdata_q <= {24'h000000, ae_low_q};
                arx_pkg::OFS_AE_HIGH:  rdata_q <= {24'h000000, ae_high_q};
                arx_pkg::OFS_RESULT:   rdata_q <= {16'h0000, fmt_result};
                arx_pkg::OFS_XFER_MOD: rdata_q <= {24'h000000, mode_rd};
                arx_pkg::OFS_XFER_CNT: rdata_q <= {24'h000000, count_q};
                arx_pkg::OFS_XFER_SA:  rdata_q <= {16'h0000, sa_q};
                arx_pkg::OFS_FORMAT:   rdata_q <= {31'h00000000, format_q};
                arx_pkg::OFS_IRQ_STAT: rdata_q <= {30'h00000000, irq_stat_q};
                arx_pkg::OFS_IRQ_MASK: rdata_q <= {30'h00000000, irq_mask_q};
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= arx_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready_in)
        begin
            rvalid_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: tb/arx_regs_properties.sv
// arx_regs_properties: bus handshake, field and transfer checks on the ports of arx_regs
// assumes it is bound into arx_regs; one clock, asynchronous reset active high
`timescale 1ns/1ps
`default_nettype none
module arx_regs_properties (
    input wire logic                       clk_in,
    input wire logic                       rst_in,
    input wire logic [arx_pkg::AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic                       s_axi_awvalid_in,
    input wire logic                       s_axi_awready_out,
    input wire logic [31:0]                s_axi_wdata_in,
    input wire logic [3:0]                 s_axi_wstrb_in,
    input wire logic                       s_axi_wvalid_in,
    input wire logic                       s_axi_wready_out,
    input wire logic [1:0]                 s_axi_bresp_out,
    input wire logic                       s_axi_bvalid_out,
    input wire logic                       s_axi_bready_in,
    input wire logic [arx_pkg::AXI_AW-1:0] s_axi_araddr_in,
    input wire logic                       s_axi_arvalid_in,
    input wire logic                       s_axi_arready_out,
    input wire logic [31:0]                s_axi_rdata_out,
    input wire logic [1:0]                 s_axi_rresp_out,
    input wire logic                       s_axi_rvalid_out,
    input wire logic                       s_axi_rready_in,
    input wire arx_pkg::arx_sample_t       sample_in,
    input wire logic [15:0]                analog_pin_enable_out,
    input wire logic                       xfer_write_out,
    input wire logic [15:0]                xfer_addr_out,
    input wire logic                       xfer_active_out,
    input wire logic                       irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ************************************************************
    // read address tracking
    // ************************************************************
    // remembers which register the pending read data belongs to
    logic [arx_pkg::AXI_AW-1:0] rd_addr_q;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            rd_addr_q <= 6'h00;
        else if (s_axi_arvalid_in && s_axi_arready_out)
            rd_addr_q <= s_axi_araddr_in;
    end

    sequence wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence wr_answer;
        !s_axi_awready_out ##1 s_axi_bvalid_out;
    endsequence

    a_write_answer: assert property (wr_taken |=> wr_answer)
        else $error("write response not on time");
    a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read data not on time");
    a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
    a_no_read_busy: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read address accepted while data pending");
    a_pins_absent: assert property (analog_pin_enable_out[11:8] == 4'h0)
        else $error("pins 11 to 8 enabled");
    a_xfer_cause: assert property (xfer_write_out |-> $past(sample_in.valid) && $past(xfer_active_out))
        else $error("transfer without a running controller");
    a_mode_reserved: assert property (s_axi_rvalid_out && rd_addr_q == arx_pkg::OFS_XFER_MOD |-> s_axi_rdata_out[31:4] == 28'h0)
        else $error("mode reserved bits not zero");
    a_result_pad: assert property (s_axi_rvalid_out && rd_addr_q == arx_pkg::OFS_RESULT |-> s_axi_rdata_out[31:16] == 16'h0)
        else $error("result upper bits not zero");
    a_high_reserved: assert property (s_axi_rvalid_out && rd_addr_q == arx_pkg::OFS_AE_HIGH |-> s_axi_rdata_out[3:0] == 4'h0)
        else $error("high enable reserved bits not zero");
endmodule
`default_nettype wire

// File: tb/testbench.sv
// testbench: register, result format, interrupt and transfer scenarios for arx_regs
// assumes arx_pkg, arx_regs and arx_regs_properties are compiled first; one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                 clk_in = 1'h0;
    logic                 rst_in = 1'h1;
    logic [5:0]           awaddr = 6'h00;
    logic [5:0]           araddr = 6'h00;
    logic [31:0]          wdata = 32'h0;
    logic                 awvalid = 1'h0;
    logic                 wvalid = 1'h0;
    logic                 bready = 1'h0;
    logic                 arvalid = 1'h0;
    logic                 rready = 1'h0;
    arx_pkg::arx_sample_t smp = '0;
    wire logic            awready, wready, bvalid, arready, rvalid, xw, xact, irq;
    wire logic [1:0]      bresp, rresp;
    wire logic [31:0]     rdata;
    wire logic [15:0]     pins, xaddr;
    logic [1:0]           bsp;
    logic [31:0]          rdv;
    logic [1:0]           rsp;
    logic [15:0]          log_q[$];
    logic [15:0]          exp_q[$] = '{16'h0200, 16'h0202, 16'h0100, 16'h0102,
                                       16'h0300, 16'h0302, 16'h0300, 16'h0302};
    logic [5:0]           rst_ofs[6] = '{arx_pkg::OFS_AE_LOW, arx_pkg::OFS_AE_HIGH,
        arx_pkg::OFS_XFER_MOD, arx_pkg::OFS_XFER_CNT, arx_pkg::OFS_XFER_SA, arx_pkg::OFS_IRQ_MASK};
    logic [9:0]           fmt_d[3] = '{10'h2C5, 10'h000, 10'h3FF};
    int                   mismatches = 0;
    int                   n_checks = 0;
    int                   cycles = 0;

    arx_regs i_arx_regs (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .sample_in(smp), .analog_pin_enable_out(pins),
        .xfer_write_out(xw), .xfer_addr_out(xaddr), .xfer_active_out(xact), .irq_out(irq));

    always #2 clk_in = ~clk_in;

    // ************************************************************
    // transfer log and hang guard
    // ************************************************************
    always @(posedge clk_in)
    begin
        cycles++;
        if (xw === 1'h1)
            log_q.push_back(xaddr);
        if (cycles == 5000)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ************************************************************
    // AXI4-Lite master tasks
    // ************************************************************
    // address and data offered together; each dropped at the edge it is taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge clk_in);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (bvalid !== 1'h1)
            @(posedge clk_in);
        bsp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk_in); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge clk_in); while (rvalid !== 1'h1);
        rdv = rdata;
        rsp = rresp;
        rready <= 1'h0;
    endtask

    task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] exp);
        rd(a);
        chk(nm, rdv, exp);
        chk("rresp", {30'h0, rsp}, {30'h0, arx_pkg::RESP_OKAY});
    endtask

    task automatic pulse(input logic [9:0] d);
        @(posedge clk_in);
        smp <= '{valid: 1'h1, data: d};
        @(posedge clk_in);
        smp.valid <= 1'h0;
        // one more edge so state taken on the strobe is visible to the caller
        @(posedge clk_in);
    endtask

    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'h0;
        foreach (rst_ofs[i]) rc("reset value", rst_ofs[i], 32'h0);
        wr(arx_pkg::OFS_AE_LOW, 32'hA5);
        wr(arx_pkg::OFS_AE_HIGH, 32'hFF);
        rc("ae_low", arx_pkg::OFS_AE_LOW, 32'hA5);
        rc("ae_high", arx_pkg::OFS_AE_HIGH, 32'hF0);
        chk("pins", {16'h0, pins}, 32'hF0A5);
        wr(arx_pkg::OFS_XFER_MOD, 32'hFF);
        rc("mode", arx_pkg::OFS_XFER_MOD, 32'h0D);
        wr(arx_pkg::OFS_XFER_MOD, 32'h00);
        foreach (fmt_d[i])
            for (int f = 0; f < 2; f++)
            begin
                wr(arx_pkg::OFS_FORMAT, 32'(f));
                pulse(fmt_d[i]);
                rc("result", arx_pkg::OFS_RESULT, (f == 1) ?
                   {16'h0, ~fmt_d[i][9], fmt_d[i][8:0], 6'h00} : {22'h0, fmt_d[i]});
            end
        wr(arx_pkg::OFS_IRQ_MASK, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(arx_pkg::OFS_IRQ_MASK, 32'h1);
        chk("irq raised", {31'h0, irq}, 32'h1);
        wr(arx_pkg::OFS_IRQ_STAT, 32'h3);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(arx_pkg::OFS_XFER_CNT, 32'h2);
        pulse(10'h011);
        chk("idle before start", {31'h0, xact}, 32'h0);
        wr(arx_pkg::OFS_XFER_SA, 32'h0200);
        chk("started", {31'h0, xact}, 32'h1);
        pulse(10'h012);
        pulse(10'h013);
        chk("one block halt", {31'h0, xact}, 32'h0);
        wr(arx_pkg::OFS_XFER_MOD, 32'h08);
        wr(arx_pkg::OFS_XFER_CNT, 32'h1);
        wr(arx_pkg::OFS_XFER_SA, 32'h0100);
        rc("block bit before done", arx_pkg::OFS_XFER_MOD, 32'h08);
        pulse(10'h021);
        rc("block one filled", arx_pkg::OFS_XFER_MOD, 32'h0A);
        pulse(10'h022);
        rc("block two filled", arx_pkg::OFS_XFER_MOD, 32'h08);
        chk("two block halt", {31'h0, xact}, 32'h0);
        wr(arx_pkg::OFS_XFER_MOD, 32'h0C);
        wr(arx_pkg::OFS_XFER_SA, 32'h0300);
        for (int k = 0; k < 4; k++)
        begin
            pulse(10'h031);
            rc("alternate", arx_pkg::OFS_XFER_MOD, (k % 2 == 0) ? 32'h0E : 32'h0C);
        end
        chk("continuous", {31'h0, xact}, 32'h1);
        rc("irq status", arx_pkg::OFS_IRQ_STAT, 32'h3);
        wr(arx_pkg::OFS_XFER_CNT, 32'h0);
        // the controller drops out one edge after the count register changes
        @(posedge clk_in);
        chk("count zero stops", {31'h0, xact}, 32'h0);
        wr(arx_pkg::OFS_XFER_SA, 32'h0400);
        pulse(10'h041);
        chk("count zero start", {31'h0, xact}, 32'h0);
        wr(6'h3C, 32'h1);
        chk("unmapped bresp", {30'h0, bsp}, {30'h0, arx_pkg::RESP_SLVERR});
        rd(6'h3C);
        chk("unmapped rdata", rdv, 32'h0);
        chk("unmapped rresp", {30'h0, rsp}, {30'h0, arx_pkg::RESP_SLVERR});
        chk("xfer count", log_q.size(), exp_q.size());
        foreach (exp_q[i]) chk("xfer addr", {16'h0, log_q[i]}, {16'h0, exp_q[i]});
        conclude();
    end
endmodule

bind arx_regs arx_regs_properties i_arx_regs_properties (.clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .sample_in(sample_in),
    .analog_pin_enable_out(analog_pin_enable_out), .xfer_write_out(xfer_write_out),
    .xfer_addr_out(xfer_addr_out), .xfer_active_out(xfer_active_out), .irq_out(irq_out));
`default_nettype wire
